// ### src/sopm_pkg.sv
// constants, types and decode functions shared by the sense-output pin mux
package sopm_pkg;

  // ***************************************************************
  // register map and widths
  // ***************************************************************
  localparam int unsigned SOPM_ADDR_W = 9;
  localparam int unsigned SOPM_DATA_W = 16;
  localparam int unsigned SOPM_LEVEL_W = 12;
  localparam int unsigned SOPM_NUM_PINS = 2;
  localparam logic [8:0] SOPM_FLAG_DIR_OFS = 9'h1C1;
  localparam logic [8:0] SOPM_FLAG_SRC_OFS = 9'h1C3;
  localparam logic [15:0] SOPM_FLAG_DIR_RST = 16'h0000;
  localparam logic [15:0] SOPM_FLAG_SRC_RST = 16'h0000;
  localparam logic [15:0] SOPM_RDATA_RST = 16'h0000;
  // flag bus line used by pin a; pin b uses the next line
  localparam int unsigned SOPM_FLAG_BIT0 = 10;

  // ***************************************************************
  // select and gain codes
  // ***************************************************************
  localparam logic [2:0] SOPM_SEL_CUR_LO = 3'h0;
  localparam logic [2:0] SOPM_SEL_CUR_HI = 3'h1;
  localparam logic [2:0] SOPM_SEL_REF = 3'h5;
  localparam logic [1:0] SOPM_GAIN_RST = 2'h0;
  localparam logic [1:0] SOPM_GAIN_1V33 = 2'h0;
  localparam logic [1:0] SOPM_GAIN_2V0 = 2'h1;
  localparam logic [1:0] SOPM_GAIN_3V0 = 2'h2;
  localparam logic [1:0] SOPM_GAIN_5V33 = 2'h3;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [3:0] {
    SOPM_SRC_NONE = 4'h1,
    SOPM_SRC_CUR_LO = 4'h2,
    SOPM_SRC_CUR_HI = 4'h4,
    SOPM_SRC_REF = 4'h8
  } sopm_src_e;

  typedef enum logic [3:0] {
    SOPM_MODE_ANA_OFF = 4'h1,
    SOPM_MODE_ANA_ON = 4'h2,
    SOPM_MODE_DIG_IN = 4'h4,
    SOPM_MODE_DIG_OUT = 4'h8
  } sopm_mode_e;

  typedef struct packed {
    logic [2:0] sel;
    logic ana_en;
    logic [1:0] gain;
    logic pin_fn;
    logic pin_dir;
    logic flag_src;
    logic flag_dir;
    logic flag_val;
  } sopm_pin_cfg_s;

  typedef struct packed {
    sopm_mode_e mode;
    sopm_src_e src;
    logic ana_drive;
    logic [1:0] gain;
    logic bias_shift;
    logic pin_out;
    logic pin_oe;
    logic flag_in;
  } sopm_pin_stat_s;

  localparam sopm_pin_stat_s SOPM_STAT_RST = '{
    mode: SOPM_MODE_ANA_OFF, src: SOPM_SRC_NONE, ana_drive: 1'b0, gain: SOPM_GAIN_RST,
    bias_shift: 1'b0, pin_out: 1'b0, pin_oe: 1'b0, flag_in: 1'b0};

  // ***************************************************************
  // decode functions
  // ***************************************************************
  // pin role from flag source/direction and per-pin function/direction
  function automatic sopm_mode_e sopm_mode_f(input sopm_pin_cfg_s c);
    sopm_mode_e m;
    m = SOPM_MODE_ANA_OFF;
    if (!c.flag_src && !c.pin_fn) begin
      m = c.ana_en ? SOPM_MODE_ANA_ON : SOPM_MODE_ANA_OFF;
    end else if (c.flag_src && !c.flag_dir && c.pin_fn && c.pin_dir) begin
      m = SOPM_MODE_DIG_OUT;
    end else if (c.pin_fn) begin
      // any other digital combination is safest as an input: buffer off
      m = SOPM_MODE_DIG_IN;
    end
    return m;
  endfunction

  // select code to measurement source, reserved codes drive nothing
  function automatic sopm_src_e sopm_src_f(input logic [2:0] sel);
    sopm_src_e s;
    s = SOPM_SRC_NONE;
    if (sel == SOPM_SEL_CUR_LO) begin
      s = SOPM_SRC_CUR_LO;
    end else if (sel == SOPM_SEL_CUR_HI) begin
      s = SOPM_SRC_CUR_HI;
    end else if (sel == SOPM_SEL_REF) begin
      s = SOPM_SRC_REF;
    end
    return s;
  endfunction

endpackage

// ### src/sopm_pin_ctl.sv
// per-pin analog/digital role control for one sense-output pin
`timescale 1ns/100ps
module sopm_pin_ctl (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire sopm_pkg::sopm_pin_cfg_s cfg,
  input wire logic pin_in,
  output sopm_pkg::sopm_pin_stat_s stat
);
  import sopm_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    sopm_pin_stat_s stat;
  } sopm_pin_state_s;

  sopm_pin_state_s state_q;
  sopm_pin_state_s state_d;
  sopm_mode_e mode;
  sopm_src_e src;

  // ***************************************************************
  // next state
  // ***************************************************************
  // decode role and source, then drive buffers from the decoded role
  always_comb begin
    mode = sopm_mode_f(cfg);
    src = sopm_src_f(cfg.sel);
    state_d = state_q;
    state_d.sync1 = pin_in;
    state_d.sync2 = state_q.sync1;
    state_d.stat.mode = mode;
    state_d.stat.src = (mode == SOPM_MODE_ANA_ON) ? src : SOPM_SRC_NONE;
    // reserved code leaves the analog path undriven
    state_d.stat.ana_drive = (mode == SOPM_MODE_ANA_ON) && (src != SOPM_SRC_NONE);
    state_d.stat.gain = cfg.gain;
    state_d.stat.bias_shift = cfg.gain[1]; // two highest gains shift by the bias
    state_d.stat.pin_oe = (mode == SOPM_MODE_DIG_OUT);
    state_d.stat.pin_out = (mode == SOPM_MODE_DIG_OUT) ? cfg.flag_val : 1'b0;
    // output buffer off and pin level handed to the flag bus
    state_d.stat.flag_in = (mode == SOPM_MODE_DIG_IN) ? state_q.sync2 : 1'b0;
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  // clock enable low freezes everything, sync chain included
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= '{sync1: 1'b0, sync2: 1'b0, stat: SOPM_STAT_RST};
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  assign stat = state_q.stat;

endmodule

// ### src/sopm_top.sv
// sense-output pin mux: flag registers, comparator and two pin controllers
`timescale 1ns/100ps
module sopm_top #(
  parameter int unsigned LEVEL_W = sopm_pkg::SOPM_LEVEL_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [sopm_pkg::SOPM_ADDR_W-1:0] reg_addr,
  input wire logic [sopm_pkg::SOPM_DATA_W-1:0] reg_wdata,
  output logic [sopm_pkg::SOPM_DATA_W-1:0] reg_rdata,
  input wire logic [2:0] first_pin_source_sel,
  input wire logic [2:0] second_pin_source_sel,
  input wire logic first_pin_analog_enable,
  input wire logic second_pin_analog_enable,
  input wire logic [1:0] out_amp_gain_code_a,
  input wire logic [1:0] out_amp_gain_code_b,
  input wire logic [1:0] pin_function_sel,
  input wire logic [1:0] pin_direction_sel,
  input wire logic [1:0] pin_flag_drive_value,
  input wire logic [LEVEL_W-1:0] sense_amp_level,
  input wire logic [LEVEL_W-1:0] neg_threshold_level,
  output logic negative_current_feedback,
  input wire logic sense_out_pin_a_in,
  output logic sense_out_pin_a_out,
  output logic sense_out_pin_a_oe,
  input wire logic sense_out_pin_b_in,
  output logic sense_out_pin_b_out,
  output logic sense_out_pin_b_oe,
  output sopm_pkg::sopm_pin_stat_s pin_a_stat,
  output sopm_pkg::sopm_pin_stat_s pin_b_stat,
  output logic [1:0] flag_bus_in
);
  import sopm_pkg::*;

  typedef struct packed {
    logic [SOPM_DATA_W-1:0] flag_pin_direction;
    logic [SOPM_DATA_W-1:0] flag_pin_source_select;
    logic [SOPM_DATA_W-1:0] rdata;
    logic neg_fb;
  } sopm_top_state_s;

  sopm_top_state_s state_q;
  sopm_top_state_s state_d;
  sopm_pin_cfg_s pin_cfg [SOPM_NUM_PINS];
  sopm_pin_stat_s pin_stat [SOPM_NUM_PINS];
  logic [SOPM_NUM_PINS-1:0] pin_raw_in;
  logic [2:0] sel_arr [SOPM_NUM_PINS];
  logic [1:0] gain_arr [SOPM_NUM_PINS];
  logic [SOPM_NUM_PINS-1:0] en_arr;

  // ***************************************************************
  // register access and comparator
  // ***************************************************************
  // reads answer one cycle later; unmapped reads return zero
  always_comb begin
    state_d = state_q;
    if (reg_wr_en) begin
      if (reg_addr == SOPM_FLAG_DIR_OFS) begin
        state_d.flag_pin_direction = reg_wdata;
      end else if (reg_addr == SOPM_FLAG_SRC_OFS) begin
        state_d.flag_pin_source_select = reg_wdata;
      end
    end
    if (reg_rd_en) begin
      if (reg_addr == SOPM_FLAG_DIR_OFS) begin
        state_d.rdata = state_q.flag_pin_direction;
      end else if (reg_addr == SOPM_FLAG_SRC_OFS) begin
        state_d.rdata = state_q.flag_pin_source_select;
      end else begin
        state_d.rdata = '0;
      end
    end
    // plain strict compare: equal levels read low, no hysteresis band
    state_d.neg_fb = (sense_amp_level > neg_threshold_level);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= '{flag_pin_direction: SOPM_FLAG_DIR_RST, flag_pin_source_select: SOPM_FLAG_SRC_RST,
                   rdata: SOPM_RDATA_RST, neg_fb: 1'b0};
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // ***************************************************************
  // per-pin configuration and controllers
  // ***************************************************************
  // core-driven select, enable and gain gathered per pin
  assign sel_arr[0] = first_pin_source_sel;
  assign sel_arr[1] = second_pin_source_sel;
  assign gain_arr[0] = out_amp_gain_code_a;
  assign gain_arr[1] = out_amp_gain_code_b;
  assign en_arr = {second_pin_analog_enable, first_pin_analog_enable};
  assign pin_raw_in = {sense_out_pin_b_in, sense_out_pin_a_in};

  // digital level is chosen by the gain code, so the core must set 00 or 01 here
  for (genvar i = 0; i < SOPM_NUM_PINS; i++) begin : g_pin
    assign pin_cfg[i] = '{
      sel: sel_arr[i],
      ana_en: en_arr[i],
      gain: gain_arr[i],
      pin_fn: pin_function_sel[i],
      pin_dir: pin_direction_sel[i],
      flag_src: state_q.flag_pin_source_select[SOPM_FLAG_BIT0+i],
      flag_dir: state_q.flag_pin_direction[SOPM_FLAG_BIT0+i],
      flag_val: pin_flag_drive_value[i]};

    sopm_pin_ctl u_pin (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .cfg(pin_cfg[i]),
      .pin_in(pin_raw_in[i]),
      .stat(pin_stat[i])
    );

    assign flag_bus_in[i] = pin_stat[i].flag_in;
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign reg_rdata = state_q.rdata;
  assign negative_current_feedback = state_q.neg_fb;
  assign pin_a_stat = pin_stat[0];
  assign pin_b_stat = pin_stat[1];
  assign sense_out_pin_a_out = pin_stat[0].pin_out;
  assign sense_out_pin_a_oe = pin_stat[0].pin_oe;
  assign sense_out_pin_b_out = pin_stat[1].pin_out;
  assign sense_out_pin_b_oe = pin_stat[1].pin_oe;

endmodule

// ### testbench/sopm_far_side.sv
// far-side model: adc input or flag bus line with weak pull-down
`timescale 1ns/100ps
module sopm_far_side (
  input wire logic pin_oe,
  input wire logic pin_out,
  input wire logic drv_en,
  input wire logic drv_val,
  output logic pin_level
);
  // released line falls to the pull-down, never keeps the old value
  assign pin_level = pin_oe ? pin_out : (drv_en & drv_val);
endmodule

// ### testbench/sopm_top_sva.sv
// assertion checker for the sense-output pin mux top
`timescale 1ns/100ps
module sopm_top_chk
  import sopm_pkg::*;
#(
  parameter int unsigned LEVEL_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic reg_rd_en,
  input wire logic [8:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic [2:0] first_pin_source_sel,
  input wire logic [2:0] second_pin_source_sel,
  input wire logic first_pin_analog_enable,
  input wire logic [1:0] out_amp_gain_code_a,
  input wire logic [1:0] pin_function_sel,
  input wire logic [LEVEL_W-1:0] sense_amp_level,
  input wire logic [LEVEL_W-1:0] neg_threshold_level,
  input wire logic negative_current_feedback,
  input wire logic sense_out_pin_a_oe,
  input wire sopm_pkg::sopm_pin_stat_s pin_a_stat,
  input wire sopm_pkg::sopm_pin_stat_s pin_b_stat
);
  // ****
  // properties
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence ref_sel_b_s;
    clk_en && second_pin_source_sel == SOPM_SEL_REF;
  endsequence
  sequence ana_on_b_s;
    pin_b_stat.mode == SOPM_MODE_ANA_ON;
  endsequence
  neg_fb_cmp_a: assert property (clk_en |=> negative_current_feedback ==
    ($past(sense_amp_level) > $past(neg_threshold_level))) else $error("neg fb wrong");
  gain_follow_a: assert property (clk_en |=> pin_a_stat.gain == $past(out_amp_gain_code_a)) else $error("gain");
  bias_shift_a: assert property (clk_en |=>
    pin_a_stat.bias_shift == ($past(out_amp_gain_code_a) >= 2'h2)) else $error("bias");
  ana_hiz_a: assert property (clk_en && !pin_function_sel[0] && !first_pin_analog_enable
    |=> !sense_out_pin_a_oe && !pin_a_stat.ana_drive) else $error("oe with enable low");
  rsvd_sel_a: assert property (clk_en && !(first_pin_source_sel inside {3'h0, 3'h1, 3'h5})
    |=> !pin_a_stat.ana_drive && pin_a_stat.src == SOPM_SRC_NONE) else $error("reserved sel drives");
  ref_sel_b_a: assert property (ref_sel_b_s ##1 ana_on_b_s |-> pin_b_stat.src == SOPM_SRC_REF) else $error("ref");
  dig_in_hiz_a: assert property (pin_a_stat.mode == SOPM_MODE_DIG_IN |-> !sense_out_pin_a_oe) else $error("dig in oe");
  dig_out_on_a: assert property (pin_b_stat.mode == SOPM_MODE_DIG_OUT
    |-> pin_b_stat.pin_oe && !pin_b_stat.ana_drive) else $error("dig out");
  rd_unmap_a: assert property (clk_en && reg_rd_en && !(reg_addr inside {9'h1C1, 9'h1C3})
    |=> reg_rdata == 16'h0000) else $error("unmapped read");
endmodule
bind sopm_top sopm_top_chk #(.LEVEL_W(LEVEL_W)) u_chk (.clk_sys, .rst_b, .clk_en, .reg_rd_en, .reg_addr,
  .reg_rdata, .first_pin_source_sel, .second_pin_source_sel, .first_pin_analog_enable, .out_amp_gain_code_a,
  .pin_function_sel, .sense_amp_level, .neg_threshold_level, .negative_current_feedback, .sense_out_pin_a_oe,
  .pin_a_stat, .pin_b_stat);

// ### testbench/sopm_top_bench.sv
// self-checking bench for the sense-output pin mux
`timescale 1ns/100ps
module sopm_top_bench;
  import sopm_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, clk_en = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic [8:0] reg_addr = 9'h000;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [2:0] first_pin_source_sel = 3'h0, second_pin_source_sel = 3'h0;
  logic first_pin_analog_enable = 1'b0, second_pin_analog_enable = 1'b0;
  logic [1:0] out_amp_gain_code_a = 2'h0, out_amp_gain_code_b = 2'h0, pin_function_sel = 2'h0;
  logic [1:0] pin_direction_sel = 2'h0, pin_flag_drive_value = 2'h0, drv_en = 2'h0, drv_val = 2'h0;
  logic [11:0] sense_amp_level = 12'h000, neg_threshold_level = 12'h000;
  logic [1:0] flag_bus_in;
  logic negative_current_feedback, sense_out_pin_a_in, sense_out_pin_a_out, sense_out_pin_a_oe;
  logic sense_out_pin_b_in, sense_out_pin_b_out, sense_out_pin_b_oe;
  // starts at the reset level so a frozen first comparator cycle has a defined expectation
  logic nfb_m = 1'b0;
  sopm_pin_stat_s pin_a_stat, pin_b_stat;
  int n_mismatch = 0, check_count = 0, src_m = 0, dir_m = 0;
  integer seed = 32'h6d45eb03, lv;
  always #2 clk_sys = ~clk_sys;
  sopm_top #(.LEVEL_W(12)) dut (.clk_sys, .rst_b, .clk_en, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .reg_rdata, .first_pin_source_sel, .second_pin_source_sel, .first_pin_analog_enable,
    .second_pin_analog_enable, .out_amp_gain_code_a, .out_amp_gain_code_b, .pin_function_sel,
    .pin_direction_sel, .pin_flag_drive_value, .sense_amp_level, .neg_threshold_level,
    .negative_current_feedback, .sense_out_pin_a_in, .sense_out_pin_a_out, .sense_out_pin_a_oe,
    .sense_out_pin_b_in, .sense_out_pin_b_out, .sense_out_pin_b_oe, .pin_a_stat, .pin_b_stat, .flag_bus_in);
  sopm_far_side far_a (.pin_oe(sense_out_pin_a_oe), .pin_out(sense_out_pin_a_out), .drv_en(drv_en[0]),
    .drv_val(drv_val[0]), .pin_level(sense_out_pin_a_in));
  sopm_far_side far_b (.pin_oe(sense_out_pin_b_oe), .pin_out(sense_out_pin_b_out), .drv_en(drv_en[1]),
    .drv_val(drv_val[1]), .pin_level(sense_out_pin_b_in));
  // ****
  // tasks
  // ****
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // sample off the edge so updates of the launching edge have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic reg_xfer(input logic wr, input logic [8:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr_en <= wr;
    reg_rd_en <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    @(negedge clk_sys);
    if (wr && a == SOPM_FLAG_SRC_OFS) src_m = d;
    if (wr && a == SOPM_FLAG_DIR_OFS) dir_m = d;
    if (!wr) chk("reg_rdata", reg_rdata, d);
  endtask
  // model of the pin role, written from the enable truth table
  task automatic chk_pin(input int i);
    logic [2:0] sl;
    logic en;
    logic [3:0] m, sr;
    logic [1:0] gn;
    logic od;
    sl = i ? second_pin_source_sel : first_pin_source_sel;
    gn = i ? out_amp_gain_code_b : out_amp_gain_code_a;
    en = i ? second_pin_analog_enable : first_pin_analog_enable;
    m = !src_m[10+i] && !pin_function_sel[i] ? (en ? 4'h2 : 4'h1) : pin_function_sel[i] ? 4'h4 : 4'h1;
    if (src_m[10+i] && !dir_m[10+i] && pin_function_sel[i] && pin_direction_sel[i]) m = 4'h8;
    sr = m != 4'h2 ? 4'h1 : sl == 3'h0 ? 4'h2 : sl == 3'h1 ? 4'h4 : sl == 3'h5 ? 4'h8 : 4'h1;
    od = (m == 4'h8) && pin_flag_drive_value[i];
    chk("mode", 16'(i ? pin_b_stat.mode : pin_a_stat.mode), 16'(m));
    chk("src", 16'(i ? pin_b_stat.src : pin_a_stat.src), 16'(sr));
    chk("pin_oe", 16'(i ? sense_out_pin_b_oe : sense_out_pin_a_oe), 16'(m == 4'h8));
    chk("ana_drive", 16'(i ? pin_b_stat.ana_drive : pin_a_stat.ana_drive), 16'(sr != 4'h1));
    chk("gain", 16'(i ? pin_b_stat.gain : pin_a_stat.gain), 16'(gn));
    chk("bias", 16'(i ? pin_b_stat.bias_shift : pin_a_stat.bias_shift), 16'(gn >= 2'h2));
    chk("pin_out", 16'(i ? sense_out_pin_b_out : sense_out_pin_a_out), 16'(od));
    chk("flag_in", 16'(flag_bus_in[i]), 16'(m == 4'h4 && drv_en[i] && drv_val[i]));
  endtask
  // ****
  // sequence
  // ****
  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    settle(11);
    chk("rst rdata", reg_rdata, 16'h0000);
    chk_pin(0);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    reg_xfer(1'b0, SOPM_FLAG_DIR_OFS, 16'h0000);
    reg_xfer(1'b1, SOPM_FLAG_SRC_OFS, 16'hA5C3);
    reg_xfer(1'b1, 9'h1C2, 16'hFFFF);
    reg_xfer(1'b0, 9'h1C2, 16'h0000);
    reg_xfer(1'b0, SOPM_FLAG_SRC_OFS, 16'hA5C3);
    // comparator, equal levels and freezes included
    repeat (40) begin
      @(posedge clk_sys);
      lv = $random(seed);
      clk_en <= lv[31] | lv[30];
      sense_amp_level <= lv[11:0];
      neg_threshold_level <= lv[0] ? lv[11:0] : lv[23:12];
      settle(1);
      if (clk_en) nfb_m = sense_amp_level > neg_threshold_level;
      chk("neg_fb", 16'(negative_current_feedback), 16'(nfb_m));
    end
    @(posedge clk_sys);
    clk_en <= 1'b1;
    // clear the source register so pin a sees the analog role in the first pass
    reg_xfer(1'b1, SOPM_FLAG_SRC_OFS, 16'h0000);
    // every select code and enable, then random digital roles
    for (int k = 0; k < 80; k++) begin
      lv = $random(seed);
      if (k >= 16) reg_xfer(1'b1, SOPM_FLAG_SRC_OFS, lv[15:0]);
      if (k >= 16) reg_xfer(1'b1, SOPM_FLAG_DIR_OFS, lv[31:16]);
      lv = $random(seed);
      @(posedge clk_sys);
      first_pin_source_sel <= k[2:0];
      second_pin_source_sel <= ~k[2:0];
      first_pin_analog_enable <= k[3];
      second_pin_analog_enable <= k[3] ^ lv[8];
      out_amp_gain_code_a <= {lv[1] & (k < 16), lv[0]};
      out_amp_gain_code_b <= {lv[9] & (k < 16), lv[3]};
      pin_flag_drive_value <= lv[5:4];
      pin_function_sel <= k < 16 ? 2'h0 : lv[7:6];
      pin_direction_sel <= lv[11:10];
      drv_en <= lv[13:12];
      drv_val <= lv[15:14];
      settle(6);
      chk_pin(0);
      chk_pin(1);
    end
    // mid-run reset must bring both flag registers back to zero, then pin roles are rechecked against the cleared registers
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    src_m = 0;
    dir_m = 0;
    reg_xfer(1'b0, SOPM_FLAG_SRC_OFS, 16'h0000);
    reg_xfer(1'b0, SOPM_FLAG_DIR_OFS, 16'h0000);
    settle(6);
    chk_pin(0);
    chk_pin(1);
    end_sim();
  end
endmodule
